/* core/pmsf_pkg.sv */
package pmsf_pkg;
   // command codes of the status registers
   localparam logic [7:0] CMD_STATUS_WORD = 8'h79;
   localparam logic [7:0] CMD_VOUT_FLAGS = 8'h7A;
   localparam logic [7:0] CMD_IOUT_FLAGS = 8'h7B;
   // page values
   localparam logic [7:0] PAGE_CH_A = 8'h00;
   localparam logic [7:0] PAGE_CH_B = 8'h01;
   localparam logic [7:0] PAGE_ALL = 8'hFF;
   // field positions, output-voltage byte
   localparam int OV_FAULT_BIT = 7;
   localparam int UV_FAULT_BIT = 4;
   localparam int VOUT_MINMAX_BIT = 3;
   // field positions, output-current byte
   localparam int IOUT_OCF_BIT = 7;
   localparam int OC_WARN_BIT = 5;
   localparam int IOUT_SHARE_BIT = 3;
   // field positions, summary word
   localparam int WORD_VOUT_BIT = 15;
   localparam int WORD_IOUT_BIT = 14;
   localparam int WORD_OC_BIT = 4;
   // supported-bit masks and reset values
   localparam logic [7:0] VOUT_MASK = 8'h98;
   localparam logic [7:0] IOUT_MASK = 8'hA8;
   localparam logic [7:0] FLAGS_RESET = 8'h00;
   localparam int NUM_CH = 2;

   typedef enum logic [1:0] {
      PMSF_RD_BYTE,
      PMSF_WR_BYTE,
      PMSF_RD_WORD,
      PMSF_WR_WORD
   } pmsf_kind_type;

   typedef struct packed {
      logic valid;
      pmsf_kind_type kind;
      logic [7:0] cmd;
      logic [7:0] wdata;
   } pmsf_req_type;

   typedef struct packed {
      logic valid;
      logic invalid;
      logic [15:0] rdata;
   } pmsf_rsp_type;

   // fault events for one channel, one-cycle pulses or levels
   typedef struct packed {
      logic ov_fault;
      logic uv_fault;
      logic minmax_hit;
      logic oc_fault;
      logic oc_warn;
      logic share_fault;
   } pmsf_evt_type;
endpackage : pmsf_pkg

/* core/pmsf_flag_bank.sv */
`timescale 1ns/10ps
module pmsf_flag_bank #(
   parameter logic [7:0] MASK = 8'h00
) (
   input wire logic sys_clk,
   input wire logic srst,
   input wire logic ce,
   input wire logic [7:0] set_vec,
   input wire logic clr_en,
   input wire logic [7:0] clr_vec,
   output logic [7:0] flags_q
);
   import pmsf_pkg::*;
   typedef struct packed {
      logic [7:0] flags;
   } pmsf_bank_type;
   pmsf_bank_type st_q, st_d;

   // set beats clear, so a still-present fault survives the clear
   always_comb begin
      st_d = st_q;
      if (clr_en) begin
         st_d.flags = st_q.flags & ~clr_vec;
      end
      st_d.flags = (st_d.flags | set_vec) & MASK;
   end

   always_ff @(posedge sys_clk) begin
      if (srst) begin
         st_q <= '{flags: FLAGS_RESET};
      end else if (ce) begin
         st_q <= st_d;
      end
   end
   assign flags_q = st_q.flags;

   a_flag_latch: assert property (@(posedge sys_clk) disable iff (srst)
      ce && (set_vec & MASK) != 8'h00 |=> (flags_q & $past(set_vec) & MASK) == ($past(set_vec) & MASK))
      else $error("latched flag missing after event"); // [R16]
   a_flag_mask: assert property (@(posedge sys_clk) disable iff (srst)
      (flags_q & ~MASK) == 8'h00)
      else $error("unsupported flag bit set"); // [R11]
endmodule : pmsf_flag_bank

/* core/pmsf_summary.sv */
`timescale 1ns/10ps
module pmsf_summary (
   input wire logic [7:0] vout_flags,
   input wire logic [7:0] iout_flags,
   output logic [15:0] word
);
   import pmsf_pkg::*;
   // purely combinational: summary bits keep no state of their own
   always_comb begin
      word = 16'h0000;
      word[WORD_VOUT_BIT] = |vout_flags; // [R1] [R14]
      word[WORD_IOUT_BIT] = |iout_flags; // [R14]
      word[WORD_OC_BIT] = iout_flags[IOUT_OCF_BIT]; // [R2] [R15]
   end
endmodule : pmsf_summary

/* core/pmsf_status_flags.sv */
// What this block does
// R1 - summary word bits derive from detailed flags
// R2 - overcurrent sets summary and detailed flag
// R3 - clearing overcurrent flag also clears summary bit
// R4 - writes to summary word are invalid
// R5 - status bytes use single-byte reads/writes only
// R6 - page 00h channel A, 01h channel B
// R7 - page FFh reads return channel A
// R8 - voltage byte bit 7 latches overvoltage
// R9 - voltage byte bit 4 latches undervoltage
// R10 - voltage byte bit 3 latches limit overrun
// R11 - unsupported voltage bits read zero, ignore writes
// R12 - write one clears flag, zero keeps
// R13 - current byte holds bits 7, 5, 3
// R14 - word bits 15/14 flag voltage/current faults
// R15 - word bit 4 mirrors overcurrent fault
// R16 - persisting fault sets flag again after clear
`timescale 1ns/10ps
module pmsf_status_flags (
   input wire logic sys_clk,
   input wire logic srst,
   input wire logic ce,
   input wire logic [7:0] page,
   input pmsf_pkg::pmsf_req_type req,
   input pmsf_pkg::pmsf_evt_type [1:0] evt,
   output pmsf_pkg::pmsf_rsp_type rsp,
   output logic [15:0] word_a_q,
   output logic [15:0] word_b_q
);
   import pmsf_pkg::*;

   ////////////////////////////////////////////////////////////////////////////////
   // decode

   function automatic logic page_is_b(input logic [7:0] pg);
      return pg == PAGE_CH_B; // [R6] [R7]
   endfunction : page_is_b

   function automatic logic page_ok(input logic [7:0] pg);
      return pg == PAGE_CH_A || pg == PAGE_CH_B || pg == PAGE_ALL;
   endfunction : page_ok

   logic wr_vout, wr_iout, page_b;
   assign page_b = page_is_b(page);
   // only single-byte writes touch flags; word write never does
   assign wr_vout = req.valid && req.kind == PMSF_WR_BYTE && req.cmd == CMD_VOUT_FLAGS; // [R5]
   assign wr_iout = req.valid && req.kind == PMSF_WR_BYTE && req.cmd == CMD_IOUT_FLAGS; // [R5]

   ////////////////////////////////////////////////////////////////////////////////
   // per-channel flag banks

   logic [1:0][7:0] vflags, iflags;
   logic [1:0][15:0] words;

   for (genvar ch = 0; ch < NUM_CH; ch++) begin : g_ch
      logic [7:0] vset, iset;
      logic sel, vclr, iclr;
      // writes with page FFh affect both channels
      assign sel = (ch == 1) ? page_b || page == PAGE_ALL : page == PAGE_CH_A || page == PAGE_ALL;
      assign vclr = wr_vout && sel; // [R6] [R12]
      assign iclr = wr_iout && sel; // [R3] [R12]
      always_comb begin
         vset = 8'h00;
         vset[OV_FAULT_BIT] = evt[ch].ov_fault; // [R8]
         vset[UV_FAULT_BIT] = evt[ch].uv_fault; // [R9]
         vset[VOUT_MINMAX_BIT] = evt[ch].minmax_hit; // [R10]
         iset = 8'h00;
         iset[IOUT_OCF_BIT] = evt[ch].oc_fault; // [R2]
         iset[OC_WARN_BIT] = evt[ch].oc_warn; // [R13]
         iset[IOUT_SHARE_BIT] = evt[ch].share_fault; // [R13]
      end
      pmsf_flag_bank #(.MASK(VOUT_MASK)) u_vout (
         .sys_clk(sys_clk),
         .srst(srst),
         .ce(ce),
         .set_vec(vset),
         .clr_en(vclr),
         .clr_vec(req.wdata),
         .flags_q(vflags[ch])
      ); // [R11] [R16]
      pmsf_flag_bank #(.MASK(IOUT_MASK)) u_iout (
         .sys_clk(sys_clk),
         .srst(srst),
         .ce(ce),
         .set_vec(iset),
         .clr_en(iclr),
         .clr_vec(req.wdata),
         .flags_q(iflags[ch])
      ); // [R13] [R16]
      pmsf_summary u_sum (
         .vout_flags(vflags[ch]),
         .iout_flags(iflags[ch]),
         .word(words[ch])
      ); // [R1]
   end

   ////////////////////////////////////////////////////////////////////////////////
   // response register

   typedef struct packed {
      pmsf_rsp_type rsp;
      logic [15:0] word_a;
      logic [15:0] word_b;
   } pmsf_state_type;
   pmsf_state_type st_q, st_d;

   logic rd_ch;
   assign rd_ch = page_b; // page FFh reads channel A [R7]

   always_comb begin
      st_d = st_q;
      st_d.word_a = words[0];
      st_d.word_b = words[1];
      st_d.rsp = '0;
      if (req.valid) begin
         st_d.rsp.valid = 1'b1;
         case (req.cmd)
            CMD_VOUT_FLAGS: begin
               if (req.kind == PMSF_RD_BYTE) begin
                  st_d.rsp.rdata = {8'h00, vflags[rd_ch]}; // [R5]
               end else if (req.kind != PMSF_WR_BYTE) begin
                  st_d.rsp.invalid = 1'b1; // [R5]
               end
               if (!page_ok(page)) begin
                  st_d.rsp.invalid = 1'b1;
               end
            end
            CMD_IOUT_FLAGS: begin
               if (req.kind == PMSF_RD_BYTE) begin
                  st_d.rsp.rdata = {8'h00, iflags[rd_ch]}; // [R5]
               end else if (req.kind != PMSF_WR_BYTE) begin
                  st_d.rsp.invalid = 1'b1; // [R5]
               end
               if (!page_ok(page)) begin
                  st_d.rsp.invalid = 1'b1;
               end
            end
            CMD_STATUS_WORD: begin
               if (req.kind == PMSF_RD_WORD) begin
                  st_d.rsp.rdata = words[rd_ch]; // [R7]
               end else begin
                  st_d.rsp.invalid = 1'b1; // [R4]
               end
            end
            default: begin
               st_d.rsp.invalid = 1'b1;
            end
         endcase
      end
   end

   always_ff @(posedge sys_clk) begin
      if (srst) begin
         st_q <= '0;
      end else if (ce) begin
         st_q <= st_d;
      end
   end

   assign rsp = st_q.rsp;
   assign word_a_q = st_q.word_a;
   assign word_b_q = st_q.word_b;

   ////////////////////////////////////////////////////////////////////////////////
   // checks

   a_word_write_invalid: assert property (@(posedge sys_clk) disable iff (srst)
      ce && req.valid && req.cmd == CMD_STATUS_WORD && req.kind != PMSF_RD_WORD
      |=> rsp.valid && rsp.invalid)
      else $error("word write not refused"); // [R4]
   a_word_write_keeps: assert property (@(posedge sys_clk) disable iff (srst)
      ce && req.valid && req.cmd == CMD_STATUS_WORD && evt == '0
      |=> vflags == $past(vflags) && iflags == $past(iflags))
      else $error("word write changed flags"); // [R4]
   a_oc_both_set: assert property (@(posedge sys_clk) disable iff (srst)
      ce && evt[1].oc_fault |=> iflags[1][IOUT_OCF_BIT] ##1 word_b_q[WORD_OC_BIT])
      else $error("overcurrent not in both places"); // [R2]
   a_oc_clear_both: assert property (@(posedge sys_clk) disable iff (srst)
      ce && wr_iout && page_b && req.wdata[IOUT_OCF_BIT] && !evt[1].oc_fault
      |=> !iflags[1][IOUT_OCF_BIT] ##1 (!ce || !word_b_q[WORD_OC_BIT]))
      else $error("overcurrent clear incomplete"); // [R3]
   a_sum_follow: assert property (@(posedge sys_clk) disable iff (srst)
      ce |=> word_b_q[WORD_VOUT_BIT] == |$past(vflags[1])
      && word_b_q[WORD_IOUT_BIT] == |$past(iflags[1]))
      else $error("summary bits disagree with flags"); // [R14] [R1]
   a_page_all_reads_a: assert property (@(posedge sys_clk) disable iff (srst)
      ce && req.valid && req.kind == PMSF_RD_BYTE && req.cmd == CMD_VOUT_FLAGS
      && page == PAGE_ALL |=> rsp.rdata[7:0] == $past(vflags[0]))
      else $error("page FFh did not read channel A"); // [R7]
   a_page_b_reads_b: assert property (@(posedge sys_clk) disable iff (srst)
      ce && req.valid && req.kind == PMSF_RD_BYTE && req.cmd == CMD_IOUT_FLAGS
      && page == PAGE_CH_B |=> rsp.rdata == {8'h00, $past(iflags[1])})
      else $error("page 01h did not read channel B"); // [R6]
   a_ov_latched: assert property (@(posedge sys_clk) disable iff (srst)
      ce && evt[0].ov_fault |=> vflags[0][OV_FAULT_BIT])
      else $error("overvoltage not latched"); // [R8]
   a_uv_latched: assert property (@(posedge sys_clk) disable iff (srst)
      ce && evt[0].uv_fault && evt[0].minmax_hit
      |=> vflags[0][UV_FAULT_BIT] && vflags[0][VOUT_MINMAX_BIT])
      else $error("undervoltage or limit flag not latched"); // [R9] [R10]
   a_zero_keeps: assert property (@(posedge sys_clk) disable iff (srst)
      ce && wr_vout && req.wdata == 8'h00 |=> vflags[0] == ($past(vflags[0]) | vflags[0]))
      else $error("writing zero cleared a flag"); // [R12]
   a_byte_only: assert property (@(posedge sys_clk) disable iff (srst)
      ce && req.valid && req.cmd == CMD_IOUT_FLAGS && req.kind == PMSF_RD_WORD
      |=> rsp.invalid)
      else $error("word access to byte register accepted"); // [R5]
   a_iout_mask: assert property (@(posedge sys_clk) disable iff (srst)
      (iflags[0] & ~IOUT_MASK) == 8'h00 && (iflags[1] & ~IOUT_MASK) == 8'h00)
      else $error("unsupported current flag set"); // [R13]

   c_oc_then_clear: cover property (@(posedge sys_clk) disable iff (srst)
      iflags[1][IOUT_OCF_BIT] ##[1:20] !iflags[1][IOUT_OCF_BIT]);
   c_read_b: cover property (@(posedge sys_clk) disable iff (srst)
      req.valid && page == PAGE_CH_B && req.kind == PMSF_RD_BYTE);
   c_word_write: cover property (@(posedge sys_clk) disable iff (srst)
      req.valid && req.cmd == CMD_STATUS_WORD && req.kind == PMSF_WR_WORD);
   c_clear_lost: cover property (@(posedge sys_clk) disable iff (srst)
      wr_vout && evt[0].ov_fault && req.wdata[OV_FAULT_BIT]);
endmodule : pmsf_status_flags

/* testbench/pmsf_host.sv */
`timescale 1ns/10ps
module pmsf_host (
   input wire logic sys_clk,
   input pmsf_pkg::pmsf_rsp_type rsp,
   output pmsf_pkg::pmsf_req_type req,
   output logic [7:0] page
);
   import pmsf_pkg::*;
   initial begin
      req = '0;
      page = PAGE_CH_A;
   end
   ////////////////////////////////////////////////////////////////////////////////
   // page is set with the request and held after it, as a bus master keeps it
   task automatic xfer(input pmsf_kind_type k, input logic [7:0] c, input logic [7:0] w,
         input logic [7:0] p, output pmsf_rsp_type r);
      @(posedge sys_clk);
      page <= p;
      req <= '{valid: 1'b1, kind: k, cmd: c, wdata: w};
      @(posedge sys_clk);
      // released cmd and wdata are scrambled so a design that samples late is caught
      req <= '{valid: 1'b0, kind: k, cmd: ~c, wdata: ~w};
      @(posedge sys_clk);
      r = rsp;
   endtask : xfer
endmodule : pmsf_host

/* testbench/pmsf_status_flags_test.sv */
`timescale 1ns/10ps
module pmsf_status_flags_test;
   import pmsf_pkg::*;
   logic sys_clk;
   logic srst;
   logic ce;
   logic [7:0] page;
   pmsf_req_type req;
   pmsf_evt_type [1:0] evt;
   pmsf_rsp_type rsp;
   pmsf_rsp_type r;
   logic [15:0] word_a_q;
   logic [15:0] word_b_q;
   int failures = 0;
   int checks = 0;
   int cycles = 0;
   pmsf_status_flags i_dut (.sys_clk(sys_clk), .srst(srst), .ce(ce), .page(page), .req(req),
      .evt(evt), .rsp(rsp), .word_a_q(word_a_q), .word_b_q(word_b_q));
   pmsf_host i_host (.sys_clk(sys_clk), .rsp(rsp), .req(req), .page(page));
   initial begin
      sys_clk = 1'b0;
      forever #12.5 sys_clk = ~sys_clk;
   end
   ////////////////////////////////////////////////////////////////////////////////
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      checks++;
      if (seen !== exp) begin
         failures++;
         $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask : check
   task automatic stop_test;
      if (failures == 0 && checks > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask : stop_test
   // read data is compared only on accepted reads
   task automatic acc(input pmsf_kind_type k, input logic [7:0] c, input logic [7:0] w,
         input logic [7:0] p, input logic inv, input logic [15:0] exp);
      i_host.xfer(k, c, w, p, r);
      check({14'h0000, r.valid, r.invalid}, {14'h0000, 1'b1, inv});
      if (!inv && (k == PMSF_RD_BYTE || k == PMSF_RD_WORD)) begin
         check(r.rdata, exp);
      end
   endtask : acc
   task automatic pulse(input int ch, input logic [5:0] e);
      @(posedge sys_clk);
      evt[ch] <= pmsf_evt_type'(e);
      @(posedge sys_clk);
      evt[ch] <= '0;
   endtask : pulse
   // a hang would stall the sequence; 2000 cycles is far beyond its length
   always @(posedge sys_clk) begin
      cycles++;
      if (cycles == 2000) begin
         failures++;
         stop_test();
      end
   end
   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      srst = 1'b1;
      ce = 1'b1;
      evt = '0;
      repeat (2) @(posedge sys_clk);
      srst <= 1'b0;
      acc(PMSF_RD_BYTE, CMD_VOUT_FLAGS, 8'h00, PAGE_CH_A, 1'b0, 16'h0000);
      acc(PMSF_RD_BYTE, CMD_IOUT_FLAGS, 8'h00, PAGE_CH_B, 1'b0, 16'h0000);
      pulse(0, 6'h38);
      acc(PMSF_RD_BYTE, CMD_VOUT_FLAGS, 8'h00, PAGE_CH_A, 1'b0, 16'h0098);
      acc(PMSF_RD_BYTE, CMD_VOUT_FLAGS, 8'h00, PAGE_CH_B, 1'b0, 16'h0000);
      acc(PMSF_RD_BYTE, CMD_VOUT_FLAGS, 8'h00, PAGE_ALL, 1'b0, 16'h0098);
      check(word_a_q, 16'h8000);
      acc(PMSF_WR_BYTE, CMD_VOUT_FLAGS, 8'h00, PAGE_CH_A, 1'b0, 16'h0000);
      acc(PMSF_RD_BYTE, CMD_VOUT_FLAGS, 8'h00, PAGE_CH_A, 1'b0, 16'h0098);
      pulse(1, 6'h07);
      acc(PMSF_RD_BYTE, CMD_IOUT_FLAGS, 8'h00, PAGE_CH_B, 1'b0, 16'h00A8);
      acc(PMSF_RD_BYTE, CMD_IOUT_FLAGS, 8'h00, PAGE_ALL, 1'b0, 16'h0000);
      check(word_b_q, 16'h4010);
      acc(PMSF_RD_WORD, CMD_STATUS_WORD, 8'h00, PAGE_CH_B, 1'b0, 16'h4010);
      acc(PMSF_WR_WORD, CMD_STATUS_WORD, 8'hFF, PAGE_CH_B, 1'b1, 16'h0000);
      acc(PMSF_WR_BYTE, CMD_STATUS_WORD, 8'hFF, PAGE_CH_B, 1'b1, 16'h0000);
      acc(PMSF_RD_WORD, CMD_IOUT_FLAGS, 8'h00, PAGE_CH_B, 1'b1, 16'h0000);
      acc(PMSF_WR_BYTE, CMD_IOUT_FLAGS, 8'hA8, 8'h02, 1'b1, 16'h0000);
      acc(PMSF_RD_BYTE, CMD_IOUT_FLAGS, 8'h00, PAGE_CH_B, 1'b0, 16'h00A8);
      acc(PMSF_WR_BYTE, CMD_IOUT_FLAGS, 8'h80, PAGE_CH_B, 1'b0, 16'h0000);
      acc(PMSF_RD_BYTE, CMD_IOUT_FLAGS, 8'h00, PAGE_CH_B, 1'b0, 16'h0028);
      check(word_b_q, 16'h4000);
      // overcurrent held as a level while the host tries to clear it
      @(posedge sys_clk);
      evt[1] <= pmsf_evt_type'(6'h04);
      acc(PMSF_WR_BYTE, CMD_IOUT_FLAGS, 8'h80, PAGE_CH_B, 1'b0, 16'h0000);
      acc(PMSF_RD_BYTE, CMD_IOUT_FLAGS, 8'h00, PAGE_CH_B, 1'b0, 16'h00A8);
      @(posedge sys_clk);
      evt[1] <= '0;
      acc(PMSF_WR_BYTE, CMD_IOUT_FLAGS, 8'hFF, PAGE_CH_B, 1'b0, 16'h0000);
      acc(PMSF_WR_BYTE, CMD_VOUT_FLAGS, 8'hFF, PAGE_CH_A, 1'b0, 16'h0000);
      acc(PMSF_RD_BYTE, CMD_VOUT_FLAGS, 8'h00, PAGE_CH_A, 1'b0, 16'h0000);
      acc(PMSF_RD_BYTE, CMD_IOUT_FLAGS, 8'h00, PAGE_CH_B, 1'b0, 16'h0000);
      // an event while the enable is low must leave no trace
      @(posedge sys_clk);
      ce <= 1'b0;
      pulse(0, 6'h20);
      @(posedge sys_clk);
      ce <= 1'b1;
      acc(PMSF_RD_BYTE, CMD_VOUT_FLAGS, 8'h00, PAGE_CH_A, 1'b0, 16'h0000);
      check(word_a_q, 16'h0000);
      check(word_b_q, 16'h0000);
      stop_test();
   end
endmodule : pmsf_status_flags_test
